// ===== inc/css_pkg.sv
// Constants and carrier types of the channel scan sequencer.
// Assumes one 20 MHz clock and a plain synchronous register port.
package css_pkg;
  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int CSS_CH_N = 8;
  localparam int CSS_CW   = 3;
  localparam int CSS_DW   = 16;
  localparam int CSS_AW   = 4;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [3:0] CSS_A_CTRL  = 4'h0;
  localparam logic [3:0] CSS_A_LIST  = 4'h1;
  localparam logic [3:0] CSS_A_COUNT = 4'h2;
  localparam logic [3:0] CSS_A_TIMER = 4'h3;
  localparam logic [3:0] CSS_A_WATCH = 4'h4;
  localparam logic [3:0] CSS_A_STAT  = 4'h5;
  // Control fields; limit enables in order low1, high1, low2, high2
  localparam int CSS_F_EXT   = 0;
  localparam int CSS_F_IMM   = 1;
  localparam int CSS_F_WATCH = 2;
  localparam int CSS_F_LIM   = 4;
  // Status fields
  localparam int CSS_S_ENA   = 0;
  localparam int CSS_S_STEP  = 1;
  localparam int CSS_S_WHOLE = 2;
  localparam int CSS_S_IDLE  = 3;
  localparam int CSS_S_HALT  = 4;
  localparam int CSS_S_BLANK = 5;
  localparam int CSS_S_WACT  = 6;
  localparam int CSS_S_CUR   = 8;
  // Reset values; a count of zero means infinite
  localparam logic [7:0]  CSS_R_CTRL  = 8'h00;
  localparam logic [7:0]  CSS_R_LIST  = 8'hff;
  localparam logic [15:0] CSS_R_COUNT = 16'h0001;
  localparam logic [15:0] CSS_R_TIMER = 16'h0000;
  localparam logic [15:0] CSS_INF     = 16'h0000;
  localparam logic [15:0] CSS_ONE     = 16'h0001;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CSS_OFF  = 2'b00,
    CSS_WAIT = 2'b01,
    CSS_MEAS = 2'b11,
    CSS_GAP  = 2'b10
  } css_state_type;

  typedef struct packed {
    logic [CSS_AW-1:0] addr;
    logic [CSS_DW-1:0] wdata;
    logic              wr;
    logic              rd;
  } css_bus_type;

  typedef struct packed {
    logic              valid;
    logic [CSS_DW-1:0] value;
    logic              over;
    logic [1:0]        low;
    logic [1:0]        high;
  } css_watch_type;

  typedef struct packed {
    css_state_type     st;
    logic [7:0]        ctrl;
    logic [7:0]        list;
    logic [15:0]       count;
    logic [15:0]       timer;
    logic [CSS_CW-1:0] watch;
    logic              ena;
    logic              step_m;
    logic              halt_req;
    logic              blank;
    logic [CSS_CW-1:0] cur;
    logic [7:0]        relay;
    logic [15:0]       remain;
    logic [15:0]       tmr;
    logic              lim_run;
    logic [15:0]       lim_rd;
    logic [3:0]        lim_q;
    logic [15:0]       disp;
    logic [15:0]       bufd;
    logic              bufw;
    logic              mreq;
    logic [15:0]       rdata;
    logic [2:0]        ext_s;
  } css_regs_type;
endpackage

// ===== rtl/css_sequencer.sv
// Channel scan sequencer: steps relays through a channel list.
// Assumes key, halt and watch inputs are one-cycle pulses on ref_clk_i;
// the external trigger pin is asynchronous and is synchronised here.
//
// Added by the designer: the register addresses and strobed register access.
`timescale 1ns/100ps
`default_nettype none
module css_sequencer
  import css_pkg::*;
(
  // Clock and reset
  input  wire logic                ref_clk_i,
  input  wire logic                rst_i,
  // Register port
  input  wire css_pkg::css_bus_type bus_i,
  output logic [css_pkg::CSS_DW-1:0] rdata_o,
  // Front panel and trigger
  input  wire logic                step_key_i,
  input  wire logic                scan_key_i,
  input  wire logic                manual_trigger_key_key_i,
  input  wire logic                halt_i,
  input  wire logic                other_key_i,
  input  wire logic                ext_manual_trigger_key_i,
  // Watched channel limit results
  input  wire css_pkg::css_watch_type watch_i,
  // Measurement path
  output logic                     meas_req_o,
  input  wire logic                meas_done_i,
  input  wire logic [css_pkg::CSS_DW-1:0] reading_i,
  output logic                     buf_wr_o,
  output logic [css_pkg::CSS_DW-1:0] buf_data_o,
  // Relays and indicators
  output logic [css_pkg::CSS_CH_N-1:0] relay_close_o,
  output logic [css_pkg::CSS_DW-1:0] disp_value_o,
  output logic                     disp_blank_o,
  output logic                     manual_trigger_key_ind_o,
  output logic                     step_ind_o,
  output logic                     whole_ind_o,
  output logic                     watch_ind_o,
  output logic                     halt_req_o
);
  import css_pkg::*;

  // ----------------------------------------------------------------
  // Channel decoding
  // ----------------------------------------------------------------
  function automatic logic [CSS_CW-1:0] first_ch(input logic [7:0] m);
    logic [CSS_CW-1:0] r;
    r = '0;
    for (int i = CSS_CH_N - 1; i >= 0; i--) begin
      if (m[i]) begin
        r = CSS_CW'(i);
      end
    end
    return r;
  endfunction

  function automatic logic [CSS_CW-1:0] next_ch(input logic [7:0] m,
                                                input logic [CSS_CW-1:0] c);
    logic [CSS_CW-1:0] r;
    logic              hit;
    r = first_ch(m);
    hit = 1'b0;
    for (int i = 0; i < CSS_CH_N; i++) begin
      if (m[i] && (CSS_CW'(i) > c) && !hit) begin
        r = CSS_CW'(i);
        hit = 1'b1;
      end
    end
    return r;
  endfunction

  function automatic logic [7:0] one_hot(input logic [CSS_CW-1:0] c);
    return 8'h01 << c;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  css_regs_type      s_reg;
  css_regs_type      s_next;
  logic [3:0]        ev;
  logic [3:0]        ev_en;
  logic              watch_act;
  logic              limit_fire;
  logic              ext_p;
  logic              manual_trigger_key;
  logic              start_k;
  logic              fin;
  logic              again;
  logic [CSS_CW-1:0] watch_eff;
  logic [CSS_CW-1:0] nxt;
  logic              wrap;
  logic              dec;
  logic              ext_m;
  logic [15:0]       stat;

  always_comb begin
    ext_m = s_reg.ctrl[CSS_F_EXT];
    // Watch channel must sit in the list
    watch_eff = s_reg.list[s_reg.watch] ? s_reg.watch
                                        : first_ch(s_reg.list);
    watch_act = s_reg.ctrl[CSS_F_WATCH] && (s_reg.list != '0);
    // Over-range forces high events on, low events off
    ev = {watch_i.high[1] | watch_i.over, watch_i.low[1] & ~watch_i.over,
          watch_i.high[0] | watch_i.over,
          watch_i.low[0] & ~watch_i.over};
    ev_en = ev & s_reg.ctrl[CSS_F_LIM +: 4];
    limit_fire = watch_act && !s_reg.ctrl[CSS_F_IMM]
                 && watch_i.valid && (ev_en != '0);
    // Only the second and third stages feed the edge detector
    ext_p = s_reg.ext_s[1] & ~s_reg.ext_s[2];
    manual_trigger_key = manual_trigger_key_key_i | ext_p;
    start_k = step_key_i | scan_key_i;
    nxt = next_ch(s_reg.list, s_reg.cur);
    wrap = (nxt <= s_reg.cur);
    dec = s_reg.step_m | wrap;
    fin = (s_reg.st == CSS_MEAS) && meas_done_i && dec
          && (s_reg.count != CSS_INF) && (s_reg.remain == CSS_ONE);
    again = fin && watch_act && !s_reg.ctrl[CSS_F_IMM]
            && (s_reg.lim_q != '0);
    stat = '0;
    stat[CSS_S_ENA] = s_reg.ena;
    stat[CSS_S_STEP] = s_reg.ena & s_reg.step_m;
    stat[CSS_S_WHOLE] = s_reg.ena & ~s_reg.step_m;
    stat[CSS_S_IDLE] = (s_reg.st == CSS_WAIT);
    stat[CSS_S_HALT] = s_reg.halt_req;
    stat[CSS_S_BLANK] = s_reg.blank;
    stat[CSS_S_WACT] = watch_act;
    stat[CSS_S_CUR +: CSS_CW] = s_reg.cur;

    s_next = s_reg;
    s_next.bufw = 1'b0;
    s_next.rdata = '0;
    s_next.ext_s = {s_reg.ext_s[1:0], ext_manual_trigger_key_i};
    if (watch_i.valid) begin
      s_next.lim_q = ev_en;
    end
    if (limit_fire) begin
      s_next.lim_rd = watch_i.value;
    end

    // --------------------------------------------------------------
    // Register port
    // --------------------------------------------------------------
    if (bus_i.rd) begin
      unique case (bus_i.addr)
        CSS_A_CTRL:  s_next.rdata = {8'h00, s_reg.ctrl};
        CSS_A_LIST:  s_next.rdata = {8'h00, s_reg.list};
        CSS_A_COUNT: s_next.rdata = s_reg.count;
        CSS_A_TIMER: s_next.rdata = s_reg.timer;
        CSS_A_WATCH: s_next.rdata = {13'h0000, watch_eff};
        CSS_A_STAT:  s_next.rdata = stat;
        default:     s_next.rdata = '0;
      endcase
    end
    if (bus_i.wr) begin
      unique case (bus_i.addr)
        CSS_A_CTRL:  s_next.ctrl = bus_i.wdata[7:0];
        CSS_A_LIST:  s_next.list = bus_i.wdata[7:0];
        CSS_A_COUNT: s_next.count = bus_i.wdata;
        CSS_A_TIMER: s_next.timer = bus_i.wdata;
        CSS_A_WATCH: s_next.watch = bus_i.wdata[CSS_CW-1:0];
        default: ;
      endcase
    end

    // --------------------------------------------------------------
    // Sequencer
    // --------------------------------------------------------------
    unique case (s_reg.st)
      CSS_OFF: begin
        if (start_k || limit_fire) begin
          s_next.ena = 1'b1;
          if (start_k) begin
            s_next.step_m = step_key_i;
          end
          s_next.lim_run = limit_fire && !start_k;
          s_next.cur = first_ch(s_reg.list);
          s_next.relay = one_hot(first_ch(s_reg.list));
          s_next.remain = s_reg.count;
          s_next.st = ext_m ? CSS_WAIT : CSS_MEAS;
        end
      end
      CSS_WAIT: begin
        if (start_k || manual_trigger_key || limit_fire) begin
          if (start_k) begin
            s_next.step_m = step_key_i;
          end
          if (s_reg.remain == '0) begin
            s_next.remain = s_reg.count;
          end
          s_next.lim_run = limit_fire && !start_k && !manual_trigger_key;
          s_next.st = CSS_MEAS;
        end
      end
      CSS_MEAS: begin
        if (meas_done_i) begin
          // Buffer port has no read interlock
          s_next.bufw = 1'b1;
          s_next.bufd = reading_i;
          s_next.blank = 1'b0;
          s_next.disp = (s_reg.lim_run && s_reg.cur == watch_eff)
                        ? s_reg.lim_rd : reading_i;
          s_next.cur = nxt;
          s_next.relay = one_hot(nxt);
          if (dec && s_reg.count != CSS_INF) begin
            s_next.remain = s_reg.remain - CSS_ONE;
          end
          s_next.tmr = s_reg.timer;
          if (fin) begin
            s_next.cur = first_ch(s_reg.list);
            s_next.relay = one_hot(first_ch(s_reg.list));
            s_next.st = CSS_WAIT;
            if (again) begin
              s_next.remain = s_reg.count;
              s_next.lim_run = 1'b1;
              s_next.st = CSS_MEAS;
            end
          end else if (dec) begin
            // Basic mode with count zero never stops here
            if (ext_m) begin
              s_next.st = CSS_WAIT;
            end else if (s_reg.timer != '0) begin
              s_next.st = CSS_GAP;
            end
          end
        end
      end
      CSS_GAP: begin
        s_next.tmr = s_reg.tmr - CSS_ONE;
        if (s_reg.tmr == CSS_ONE) begin
          s_next.st = CSS_MEAS;
        end
      end
    endcase

    // Entering external mode blanks even over a landing reading
    if (bus_i.wr && (bus_i.addr == CSS_A_CTRL)
        && bus_i.wdata[CSS_F_EXT] && !ext_m) begin
      s_next.blank = 1'b1;
    end
    if (halt_i) begin
      s_next.ena = 1'b0;
      s_next.st = CSS_OFF;
      s_next.relay = '0;
      s_next.lim_run = 1'b0;
      s_next.halt_req = 1'b0;
    end
    // Set beats the halt clear in the same cycle
    if (other_key_i && s_reg.ena) begin
      s_next.halt_req = 1'b1;
    end
    s_next.mreq = (s_next.st == CSS_MEAS)
                  && ((s_reg.st != CSS_MEAS) || meas_done_i);
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      s_reg <= '{st: CSS_OFF, ctrl: CSS_R_CTRL, list: CSS_R_LIST,
                 count: CSS_R_COUNT, timer: CSS_R_TIMER,
                 step_m: 1'b1, default: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rdata_o = s_reg.rdata;
  assign meas_req_o = s_reg.mreq;
  assign buf_wr_o = s_reg.bufw;
  assign buf_data_o = s_reg.bufd;
  assign relay_close_o = s_reg.relay;
  assign disp_value_o = s_reg.disp;
  assign disp_blank_o = s_reg.blank;
  assign manual_trigger_key_ind_o = s_reg.ctrl[CSS_F_EXT];
  assign step_ind_o = stat[CSS_S_STEP];
  assign whole_ind_o = stat[CSS_S_WHOLE];
  assign watch_ind_o = watch_act;
  assign halt_req_o = s_reg.halt_req;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  halt_disables_a: assert property (halt_i |=> !s_reg.ena && !step_ind_o
    && !whole_ind_o && relay_close_o == '0)
    else $error("halt did not disable scan");
  meas_listed_a: assert property (meas_req_o |-> $onehot(relay_close_o)
    && (relay_close_o & s_reg.list) != '0)
    else $error("measuring an unlisted channel");
  finish_first_a: assert property (fin && !again && !halt_i |=>
    s_reg.st == CSS_WAIT && s_reg.ena
    && relay_close_o == one_hot(first_ch(s_reg.list)))
    else $error("finish did not return to first channel");
  halt_flag_a: assert property (other_key_i && s_reg.ena |=>
    halt_req_o [*1] ##1 (halt_req_o || $past(halt_i)))
    else $error("halt required flag lost");
  ext_waits_a: assert property (s_reg.st == CSS_WAIT && !start_k
    && !manual_trigger_key && !limit_fire && !halt_i |=> !meas_req_o)
    else $error("advance without a trigger");
  ext_blank_a: assert property (bus_i.wr && bus_i.addr == CSS_A_CTRL
    && bus_i.wdata[CSS_F_EXT] && !manual_trigger_key_ind_o |=> disp_blank_o
    && manual_trigger_key_ind_o)
    else $error("external mode did not blank");
  gap_hold_a: assert property ($rose(s_reg.st == CSS_GAP)
    && s_reg.tmr != CSS_ONE |-> !meas_req_o [*2])
    else $error("timer gap skipped");
  watch_off_a: assert property (!s_reg.ctrl[CSS_F_WATCH]
    && s_reg.st == CSS_OFF && !start_k |=> s_reg.st == CSS_OFF)
    else $error("limit start while watch off");
  watch_member_a: assert property (s_reg.list != '0 |->
    s_reg.list[watch_eff])
    else $error("watched channel not in list");
  buf_write_a: assert property (s_reg.st == CSS_MEAS && meas_done_i
    |=> buf_wr_o && buf_data_o == $past(reading_i))
    else $error("reading not written to buffer");
  step_next_a: assert property (s_reg.st == CSS_MEAS && meas_done_i
    && s_reg.step_m && !fin && !halt_i
    |=> relay_close_o == one_hot($past(nxt)))
    else $error("stepping did not close next channel");
  pass_cont_a: assert property (s_reg.st == CSS_MEAS && meas_done_i
    && !dec && !halt_i |=> meas_req_o)
    else $error("whole-list pass stalled");
  count_step_a: assert property (s_reg.st == CSS_MEAS && dec
    && meas_done_i && s_reg.count != CSS_INF && !fin && !halt_i
    |=> s_reg.remain == $past(s_reg.remain) - CSS_ONE)
    else $error("reading count not decremented");
  inf_repeat_a: assert property (s_reg.st == CSS_MEAS && meas_done_i
    && s_reg.count == CSS_INF && !ext_m && !halt_i
    |=> s_reg.st != CSS_WAIT && s_reg.ena)
    else $error("infinite scan stopped");
  limit_start_a: assert property (s_reg.st == CSS_OFF && limit_fire
    && !start_k && !halt_i |=> s_reg.ena && s_reg.lim_run
    && s_reg.lim_rd == $past(watch_i.value))
    else $error("limit event did not start scan");
  idle_wake_a: assert property (s_reg.st == CSS_WAIT && !halt_i
    && (start_k || manual_trigger_key) |=> meas_req_o)
    else $error("key did not leave idle");
  scan_rerun_a: assert property (again && !halt_i |=> meas_req_o
    && s_reg.remain == $past(s_reg.count))
    else $error("event at finish did not rerun");
  limit_style_a: assert property (limit_fire && !start_k && !halt_i
    && (s_reg.st == CSS_OFF || s_reg.st == CSS_WAIT)
    |=> s_reg.step_m == $past(s_reg.step_m))
    else $error("limit start changed scan style");
endmodule
`default_nettype wire

// ===== test/css_meter_model.sv
// Far-side model: measurement path and an external trigger instrument.
// Assumes requests are one-cycle pulses; answers each after three cycles.
`timescale 1ns/100ps
`default_nettype none
module css_meter_model (
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  // Measurement handshake
  input  wire logic        meas_req_i,
  output logic             meas_done_o,
  output logic [15:0]      reading_o,
  // External trigger instrument
  input  wire logic        ext_fire_i,
  output logic             ext_manual_trigger_key_o
);
  // ----------------------------------------------------------------
  // Measurement answer
  // ----------------------------------------------------------------
  logic [2:0]  dly_reg;
  logic [15:0] val_reg;
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      dly_reg     <= 3'h0;
      val_reg     <= 16'ha000;
      meas_done_o <= 1'b0;
    end else begin
      meas_done_o <= (dly_reg == 3'h1);
      if (meas_req_i) begin
        dly_reg <= 3'h3;
      end else if (dly_reg != 3'h0) begin
        dly_reg <= dly_reg - 3'h1;
      end
      if (dly_reg == 3'h1) begin
        val_reg <= val_reg + 16'h0001;
      end
    end
  end
  // Outside the done cycle the reading is not held: show its inverse
  assign reading_o = meas_done_o ? val_reg : ~val_reg;
  // ----------------------------------------------------------------
  // Trigger pulse, deliberately off the clock phase
  // ----------------------------------------------------------------
  initial begin
    ext_manual_trigger_key_o = 1'b0;
    forever begin
      @(posedge ref_clk_i iff ext_fire_i);
      #17 ext_manual_trigger_key_o = 1'b1;
      #180 ext_manual_trigger_key_o = 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== test/tb_css_sequencer.sv
// Self-checking testbench of the channel scan sequencer.
// Assumes the meter model on the far side and a 20 MHz clock.
`timescale 1ns/100ps
`default_nettype none
module tb_css_sequencer;
  import css_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic          ref_clk_i;
  logic          rst_i;
  css_bus_type   bus;
  css_watch_type wv;
  logic [4:0]    kv;
  logic          fire, etrig, mreq, mdone, bwr, blank, tind;
  logic          sind, wind, wact, hreq;
  logic [15:0]   rdata, rdg, bdata, disp, rlast;
  logic [7:0]    relay;
  logic [7:0]    chq[$];
  int            gap, dcyc, cyc, error_cnt, checks_done;

  css_sequencer uut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .bus_i(bus),
    .rdata_o(rdata), .step_key_i(kv[0]), .scan_key_i(kv[1]),
    .manual_trigger_key_key_i(kv[2]), .halt_i(kv[3]), .other_key_i(kv[4]),
    .ext_manual_trigger_key_i(etrig), .watch_i(wv), .meas_req_o(mreq),
    .meas_done_i(mdone), .reading_i(rdg), .buf_wr_o(bwr),
    .buf_data_o(bdata), .relay_close_o(relay), .disp_value_o(disp),
    .disp_blank_o(blank), .manual_trigger_key_ind_o(tind), .step_ind_o(sind),
    .whole_ind_o(wind), .watch_ind_o(wact), .halt_req_o(hreq));

  css_meter_model meter (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .meas_req_i(mreq), .meas_done_o(mdone), .reading_o(rdg),
    .ext_fire_i(fire), .ext_manual_trigger_key_o(etrig));
  // ----------------------------------------------------------------
  // Clock, request log and hang guard
  // ----------------------------------------------------------------
  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    cyc  <= cyc + 1;
    dcyc <= mdone ? 0 : dcyc + 1;
    if (mreq) begin
      chq.push_back(relay);
      gap <= dcyc;
    end
    if (mdone) begin
      rlast <= rdg;
    end
    if (bwr) begin
      chk("buffer data", rlast, bdata);
    end
    if (cyc == 20000) begin
      error_cnt++;
      end_of_test();
    end
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge ref_clk_i);
    bus.wr <= 1'b0;
  endtask
  task automatic rchk(input string nm, input logic [3:0] a,
                      input logic [15:0] e);
    @(posedge ref_clk_i);
    bus <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge ref_clk_i);
    bus.rd <= 1'b0;
    @(negedge ref_clk_i);
    chk(nm, e, rdata);
  endtask
  task automatic key(input int b);
    @(posedge ref_clk_i);
    kv[b] <= 1'b1;
    @(posedge ref_clk_i);
    kv[b] <= 1'b0;
    @(negedge ref_clk_i);
  endtask
  task automatic evt(input logic ov, input logic [1:0] lo,
                     input logic [1:0] hi);
    @(posedge ref_clk_i);
    wv <= '{1'b1, 16'h8123, ov, lo, hi};
    @(posedge ref_clk_i);
    wv.valid <= 1'b0;
  endtask
  // Wait for n requests, then compare the channel of each (nibble list)
  task automatic run(input int n, input logic [31:0] e);
    int k;
    k = 0;
    while (chq.size() < n && k < 3000) begin
      @(posedge ref_clk_i);
      k++;
    end
    repeat (12) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    chk("request count", 16'h0001, 16'(chq.size() >= n));
    for (int i = 0; i < n && i < chq.size(); i++) begin
      chk("channel", 16'(8'h01 << e[4*i +: 4]), 16'(chq[i]));
    end
  endtask
  task automatic quiet(input int c, input int n);
    repeat (c) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    chk("no request", 16'(n), 16'(chq.size()));
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    bus = '0;
    wv = '0;
    kv = 5'h00;
    fire = 1'b0;
    cyc = 0;
    dcyc = 0;
    gap = 0;
    error_cnt = 0;
    checks_done = 0;
    rst_i = 1'b1;
    repeat (5) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    rchk("ctrl", CSS_A_CTRL, 16'h0000);
    rchk("list", CSS_A_LIST, 16'h00ff);
    rchk("count", CSS_A_COUNT, 16'h0001);
    rchk("timer", CSS_A_TIMER, 16'h0000);
    wr(CSS_A_STAT, 16'hffff);
    rchk("status", CSS_A_STAT, 16'h0000);
    wr(4'hf, 16'h1234);
    rchk("unmapped", 4'hf, 16'h0000);
    wr(CSS_A_LIST, 16'h00fc);
    wr(CSS_A_WATCH, 16'h0001);
    rchk("watch fallback", CSS_A_WATCH, 16'h0002);
    $display("test registers done");
    // Stepping, finite count, idle, restart, refused keys, halt
    wr(CSS_A_LIST, 16'h0005);
    wr(CSS_A_COUNT, 16'h0002);
    key(0);
    run(2, 32'h20);
    chk("relay at finish", 16'h0001, 16'(relay));
    rchk("status idle", CSS_A_STAT, 16'h000b);
    chq.delete();
    key(0);
    run(2, 32'h20);
    chk("halt required", 16'h0000, 16'(hreq));
    key(4);
    chk("halt required", 16'h0003, 16'({hreq, sind}));
    quiet(20, 2);
    key(3);
    chk("halt cleared", 16'h0000, 16'({hreq, sind, relay}));
    $display("test stepping done");
    // External trigger, whole-list passes
    wr(CSS_A_CTRL, 16'h0001);
    @(negedge ref_clk_i);
    chk("trigger light", 16'h0003, 16'({tind, blank}));
    wr(CSS_A_LIST, 16'h0006);
    chq.delete();
    key(1);
    quiet(30, 0);
    chk("first closed", 16'h0002, 16'(relay));
    key(2);
    run(2, 32'h21);
    quiet(30, 2);
    chq.delete();
    @(posedge ref_clk_i);
    fire <= 1'b1;
    @(posedge ref_clk_i);
    fire <= 1'b0;
    run(2, 32'h21);
    chk("blank and style", 16'h0001, 16'({blank, wind}));
    key(3);
    wr(CSS_A_CTRL, 16'h0000);
    $display("test whole list done");
    // Infinite count with a timer gap between channels
    wr(CSS_A_COUNT, 16'h0000);
    wr(CSS_A_LIST, 16'h0005);
    wr(CSS_A_TIMER, 16'h0010);
    chq.delete();
    key(0);
    run(6, 32'h202020);
    chk("timer gap", 16'h0001, 16'(gap >= 16));
    key(3);
    wr(CSS_A_TIMER, 16'h0000);
    repeat (10) @(posedge ref_clk_i);
    $display("test infinite done");
    // Limit-started scans on watched channel 2
    wr(CSS_A_COUNT, 16'h0002);
    wr(CSS_A_WATCH, 16'h0002);
    wr(CSS_A_CTRL, 16'h0024);
    @(negedge ref_clk_i);
    chk("watch light", 16'h0001, 16'(wact));
    chq.delete();
    evt(1'b1, 2'b11, 2'b00);
    evt(1'b0, 2'b00, 2'b00);
    run(2, 32'h20);
    quiet(20, 2);
    chk("watch reading", 16'h8123, disp);
    chq.delete();
    key(0);
    run(2, 32'h20);
    chq.delete();
    evt(1'b0, 2'b00, 2'b01);
    run(4, 32'h2020);
    key(3);
    evt(1'b0, 2'b00, 2'b00);
    repeat (10) @(posedge ref_clk_i);
    wr(CSS_A_CTRL, 16'h0026);
    chq.delete();
    evt(1'b0, 2'b00, 2'b01);
    quiet(40, 0);
    wr(CSS_A_CTRL, 16'h0020);
    @(negedge ref_clk_i);
    chk("watch light", 16'h0000, 16'(wact));
    chq.delete();
    evt(1'b0, 2'b00, 2'b01);
    quiet(40, 0);
    $display("test limit start done");
    end_of_test();
  end
endmodule
`default_nettype wire
